// >>> csr_pkg.sv
// Package: opcodes, addresses, states and carriers for the stack/rotate/bit executor
package csr_pkg;
    // Opcodes
    localparam logic [7:0] OP_OR_TO_MEM    = 8'h42;
    localparam logic [7:0] OP_POP          = 8'hD0;
    localparam logic [7:0] OP_PUSH         = 8'hC0;
    localparam logic [7:0] OP_SUB_EXIT     = 8'h22;
    localparam logic [7:0] OP_INT_EXIT     = 8'h32;
    localparam logic [7:0] OP_ROT_L        = 8'h23;
    localparam logic [7:0] OP_ROT_LC       = 8'h33;
    localparam logic [7:0] OP_ROT_R        = 8'h03;
    localparam logic [7:0] OP_ROT_RC       = 8'h13;
    localparam logic [7:0] OP_SET_CARRY    = 8'hD3;
    localparam logic [7:0] OP_SET_BIT      = 8'hD2;
    localparam logic [7:0] OP_SHORT_JUMP   = 8'h80;
    // Special addresses and reset values
    localparam logic [7:0] ADDR_ACC        = 8'hE0;
    localparam logic [7:0] ADDR_STATUS     = 8'hD0;
    localparam logic [7:0] ADDR_STACK_PTR  = 8'h81;
    localparam logic [7:0] STACK_PTR_RST   = 8'h07;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;
    localparam logic [15:0] PC_RST         = 16'h0000;
    localparam logic [15:0] PC_STEP_ONE    = 16'h0001;
    localparam logic [15:0] PC_STEP_TWO    = 16'h0002;
    localparam logic [7:0] SP_STEP         = 8'h01;
    // Status word field positions
    localparam int STAT_CY  = 7;
    localparam int STAT_PAR = 0;
    // Bit address space: upper half maps bytes at multiples of eight
    localparam int BIT_AREA_SEL = 7;
    localparam logic [7:0] BIT_RAM_BASE    = 8'h20;
    localparam logic [1:0] LVL_NONE        = 2'h0;

    typedef enum logic [2:0] {
        CSR_EXEC = 3'b001,
        CSR_TWO  = 3'b010,
        CSR_INT  = 3'b100
    } csr_state_t;

    // Fetched instruction as presented to the executor
    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
        logic [7:0] operand;
    } csr_instr_t;

    // Interrupt request pair
    typedef struct packed {
        logic       high;
        logic       low;
    } csr_irq_t;
endpackage

// >>> csr_bit_unit.sv
// Rotate and bit-address decode helpers for the executor
`timescale 1ns/1ps
`default_nettype none
module csr_bit_unit (
    // Operation select
    input  wire logic [7:0] opcode,
    // Operands
    input  wire logic [7:0] acc,
    input  wire logic       carry,
    input  wire logic [7:0] bit_addr,
    // Results
    output logic [7:0]      acc_out,
    output logic            carry_out,
    output logic [7:0]      byte_addr,
    output logic [2:0]      bit_pos
);
    always_comb begin
        acc_out   = acc;
        carry_out = carry;
        case (opcode)
            csr_pkg::OP_ROT_L:  acc_out = {acc[6:0], acc[7]};
            csr_pkg::OP_ROT_LC: {carry_out, acc_out} = {acc, carry};
            csr_pkg::OP_ROT_R:  acc_out = {acc[0], acc[7:1]};
            csr_pkg::OP_ROT_RC: {acc_out, carry_out} = {carry, acc};
            default: begin
                acc_out   = acc;
                carry_out = carry;
            end
        endcase
    end

    // Low half of bit space lives in RAM, high half in byte-aligned registers
    always_comb begin
        bit_pos = bit_addr[2:0];
        if (bit_addr[csr_pkg::BIT_AREA_SEL]) begin
            byte_addr = {bit_addr[7:3], 3'h0};
        end else begin
            byte_addr = csr_pkg::BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
        end
    end
endmodule
`default_nettype wire

// >>> csr_exec.sv
// Executor for OR-to-memory, stack, return, rotate, set and short jump instructions
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module csr_exec (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    // Instruction stream from fetch, same clock
    input  wire csr_pkg::csr_instr_t instr,
    output logic                    instr_ready,
    // Interrupt requests and vectors, same clock
    input  wire csr_pkg::csr_irq_t  irq,
    input  wire logic [15:0]        irq_vector_high,
    input  wire logic [15:0]        irq_vector_low,
    // Visible core state
    output logic [15:0]             pc,
    output logic [7:0]              acc,
    output logic [7:0]              stack_ptr,
    output logic [7:0]              status_word,
    output logic [1:0]              active_levels
);
    logic [7:0] mem_r [256];
    logic [7:0] mem_nxt [256];
    csr_pkg::csr_state_t state_r, state_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [7:0]  acc_r, acc_nxt, sp_r, sp_nxt, psw_r, psw_nxt, hold_r, hold_nxt;
    logic [1:0]  lvl_r, lvl_nxt;
    logic        exit_int_r, exit_int_nxt;
    logic [7:0]  rot_acc, byte_addr;
    logic        rot_cy;
    logic [2:0]  bit_pos;

    function automatic logic parity8(input logic [7:0] v);
        return ^v;
    endfunction

    csr_bit_unit u_bits (
        .opcode    (instr.opcode),
        .acc       (acc_r),
        .carry     (psw_r[csr_pkg::STAT_CY]),
        .bit_addr  (instr.operand),
        .acc_out   (rot_acc),
        .carry_out (rot_cy),
        .byte_addr (byte_addr),
        .bit_pos   (bit_pos)
    );

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [7:0] val;
        val          = csr_pkg::BYTE_ZERO;
        mem_nxt      = mem_r;
        state_nxt    = state_r;
        pc_nxt       = pc_r;
        acc_nxt      = acc_r;
        sp_nxt       = sp_r;
        psw_nxt      = psw_r;
        hold_nxt     = hold_r;
        lvl_nxt      = lvl_r;
        exit_int_nxt = exit_int_r;
        case (state_r)
            csr_pkg::CSR_EXEC: begin
                // High level pre-empts low; a level in service blocks itself
                if (irq.high && !lvl_r[1]) begin
                    state_nxt = csr_pkg::CSR_INT;
                    hold_nxt  = 8'h01;
                    sp_nxt    = sp_r + csr_pkg::SP_STEP;
                    mem_nxt[sp_r + csr_pkg::SP_STEP] = pc_r[7:0];
                end else if (irq.low && lvl_r == csr_pkg::LVL_NONE) begin
                    state_nxt = csr_pkg::CSR_INT;
                    hold_nxt  = 8'h00;
                    sp_nxt    = sp_r + csr_pkg::SP_STEP;
                    mem_nxt[sp_r + csr_pkg::SP_STEP] = pc_r[7:0];
                end else if (instr.valid) begin
                    case (instr.opcode)
                        csr_pkg::OP_OR_TO_MEM: begin
                            mem_nxt[instr.operand] = mem_r[instr.operand] | acc_r;
                            pc_nxt = pc_r + csr_pkg::PC_STEP_TWO;
                        end
                        csr_pkg::OP_POP, csr_pkg::OP_PUSH: begin
                            state_nxt = csr_pkg::CSR_TWO;
                            hold_nxt  = instr.operand;
                        end
                        csr_pkg::OP_SUB_EXIT, csr_pkg::OP_INT_EXIT: begin
                            // Upper PC byte first
                            pc_nxt[15:8] = mem_r[sp_r];
                            sp_nxt       = sp_r - csr_pkg::SP_STEP;
                            exit_int_nxt = (instr.opcode == csr_pkg::OP_INT_EXIT);
                            state_nxt    = csr_pkg::CSR_TWO;
                        end
                        csr_pkg::OP_ROT_L, csr_pkg::OP_ROT_R: begin
                            acc_nxt = rot_acc;
                            pc_nxt  = pc_r + csr_pkg::PC_STEP_ONE;
                        end
                        csr_pkg::OP_ROT_LC, csr_pkg::OP_ROT_RC: begin
                            acc_nxt = rot_acc;
                            psw_nxt[csr_pkg::STAT_CY] = rot_cy;
                            pc_nxt  = pc_r + csr_pkg::PC_STEP_ONE;
                        end
                        csr_pkg::OP_SET_CARRY: begin
                            psw_nxt[csr_pkg::STAT_CY] = 1'b1;
                            pc_nxt = pc_r + csr_pkg::PC_STEP_ONE;
                        end
                        csr_pkg::OP_SET_BIT: begin
                            // Status word and accumulator are real registers here
                            if (byte_addr == csr_pkg::ADDR_STATUS) begin
                                psw_nxt[bit_pos] = 1'b1;
                            end else if (byte_addr == csr_pkg::ADDR_ACC) begin
                                acc_nxt[bit_pos] = 1'b1;
                            end else begin
                                mem_nxt[byte_addr][bit_pos] = 1'b1;
                            end
                            pc_nxt = pc_r + csr_pkg::PC_STEP_TWO;
                        end
                        csr_pkg::OP_SHORT_JUMP: begin
                            state_nxt = csr_pkg::CSR_TWO;
                            hold_nxt  = instr.operand;
                            pc_nxt    = pc_r + csr_pkg::PC_STEP_TWO;
                        end
                        default: pc_nxt = pc_r + csr_pkg::PC_STEP_ONE;
                    endcase
                end
            end
            csr_pkg::CSR_TWO: begin
                state_nxt = csr_pkg::CSR_EXEC;
                case (instr.opcode)
                    csr_pkg::OP_POP: begin
                        val = mem_r[sp_r];
                        if (hold_r == csr_pkg::ADDR_STATUS) begin
                            psw_nxt = val;
                        end else if (hold_r == csr_pkg::ADDR_ACC) begin
                            acc_nxt = val;
                        end else if (hold_r != csr_pkg::ADDR_STACK_PTR) begin
                            mem_nxt[hold_r] = val;
                        end
                        // Pointer pop: decrement applies to the popped value
                        sp_nxt = ((hold_r == csr_pkg::ADDR_STACK_PTR) ? val : sp_r)
                                 - csr_pkg::SP_STEP;
                        pc_nxt = pc_r + csr_pkg::PC_STEP_TWO;
                    end
                    csr_pkg::OP_PUSH: begin
                        if (hold_r == csr_pkg::ADDR_STATUS) val = psw_r;
                        else if (hold_r == csr_pkg::ADDR_ACC) val = acc_r;
                        // Pointer push stores the already raised value
                        else if (hold_r == csr_pkg::ADDR_STACK_PTR) val = sp_r + csr_pkg::SP_STEP;
                        else val = mem_r[hold_r];
                        sp_nxt = sp_r + csr_pkg::SP_STEP;
                        mem_nxt[sp_r + csr_pkg::SP_STEP] = val;
                        pc_nxt = pc_r + csr_pkg::PC_STEP_TWO;
                    end
                    csr_pkg::OP_SUB_EXIT, csr_pkg::OP_INT_EXIT: begin
                        pc_nxt[7:0] = mem_r[sp_r];
                        sp_nxt      = sp_r - csr_pkg::SP_STEP;
                        if (exit_int_r) begin
                            // Release the innermost level in service
                            if (lvl_r[1]) lvl_nxt[1] = 1'b0;
                            else lvl_nxt[0] = 1'b0;
                        end
                    end
                    default: begin
                        // Offset is signed, relative to advanced PC, no page limit
                        pc_nxt = pc_r + {{8{hold_r[7]}}, hold_r};
                    end
                endcase
            end
            csr_pkg::CSR_INT: begin
                // Second byte of return address, then jump to vector
                sp_nxt = sp_r + csr_pkg::SP_STEP;
                mem_nxt[sp_r + csr_pkg::SP_STEP] = pc_r[15:8];
                pc_nxt = hold_r[0] ? irq_vector_high : irq_vector_low;
                lvl_nxt[hold_r[0]] = 1'b1;
                state_nxt = csr_pkg::CSR_EXEC;
            end
            default: state_nxt = csr_pkg::CSR_EXEC;
        endcase
        // Parity always tracks the accumulator
        psw_nxt[csr_pkg::STAT_PAR] = parity8(acc_nxt);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= csr_pkg::CSR_EXEC;
            pc_r       <= csr_pkg::PC_RST;
            acc_r      <= csr_pkg::BYTE_ZERO;
            sp_r       <= csr_pkg::STACK_PTR_RST;
            psw_r      <= csr_pkg::BYTE_ZERO;
            hold_r     <= csr_pkg::BYTE_ZERO;
            lvl_r      <= csr_pkg::LVL_NONE;
            exit_int_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            pc_r       <= pc_nxt;
            acc_r      <= acc_nxt;
            sp_r       <= sp_nxt;
            psw_r      <= psw_nxt;
            hold_r     <= hold_nxt;
            lvl_r      <= lvl_nxt;
            exit_int_r <= exit_int_nxt;
        end
    end

    // Data memory has no reset, as in a real core RAM
    always_ff @(posedge clk_sys) begin
        mem_r <= mem_nxt;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) instr_ready <= 1'b0;
        else instr_ready <= (state_nxt == csr_pkg::CSR_EXEC);
    end

    assign pc            = pc_r;
    assign acc           = acc_r;
    assign stack_ptr     = sp_r;
    assign status_word   = psw_r;
    assign active_levels = lvl_r;

    //////////////////////////////////////////////////////////////////////////
    a_or_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == csr_pkg::CSR_EXEC && !irq.high && !irq.low && instr.valid
        && instr.opcode == csr_pkg::OP_OR_TO_MEM
        && instr.operand != csr_pkg::ADDR_ACC
        |=> mem_r[$past(instr.operand)] == ($past(mem_r[instr.operand]) | $past(acc_r)))
        else $error("or to memory wrong");
    a_push_sp_up: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == csr_pkg::CSR_TWO && instr.opcode == csr_pkg::OP_PUSH
        |=> sp_r == $past(sp_r) + csr_pkg::SP_STEP)
        else $error("push pointer wrong");
    a_pop_sp_down: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == csr_pkg::CSR_TWO && instr.opcode == csr_pkg::OP_POP
        && hold_r != csr_pkg::ADDR_STACK_PTR
        |=> sp_r == $past(sp_r) - csr_pkg::SP_STEP)
        else $error("pop pointer wrong");
    a_parity_acc: assert property (@(posedge clk_sys) disable iff (!reset_n)
        1'b1 |=> psw_r[csr_pkg::STAT_PAR] == ^acc_r)
        else $error("parity mismatch");
    a_pop_status: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == csr_pkg::CSR_TWO && instr.opcode == csr_pkg::OP_POP
        && hold_r == csr_pkg::ADDR_STATUS
        |=> psw_r[csr_pkg::STAT_CY] == $past(mem_r[sp_r][csr_pkg::STAT_CY])
            && psw_r[csr_pkg::STAT_PAR] == ^acc_r)
        else $error("pop to status wrong");
    a_rot_left: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == csr_pkg::CSR_EXEC && !irq.high && !irq.low && instr.valid
        && instr.opcode == csr_pkg::OP_ROT_L
        |=> acc_r == {$past(acc_r[6:0]), $past(acc_r[7])})
        else $error("rotate left wrong");
    a_rot_rc: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == csr_pkg::CSR_EXEC && !irq.high && !irq.low && instr.valid
        && instr.opcode == csr_pkg::OP_ROT_RC
        |=> psw_r[csr_pkg::STAT_CY] == $past(acc_r[0])
            && acc_r[7] == $past(psw_r[csr_pkg::STAT_CY]))
        else $error("rotate right carry wrong");
    a_set_carry: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == csr_pkg::CSR_EXEC && !irq.high && !irq.low && instr.valid
        && instr.opcode == csr_pkg::OP_SET_CARRY |=> psw_r[csr_pkg::STAT_CY])
        else $error("carry not set");
    a_short_relative_jump_target: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == csr_pkg::CSR_EXEC && !irq.high && !irq.low && instr.valid
        && instr.opcode == csr_pkg::OP_SHORT_JUMP
        |=> ##1 pc_r == $past(pc_r, 2) + csr_pkg::PC_STEP_TWO
            + {{8{$past(instr.operand[7], 2)}}, $past(instr.operand, 2)})
        else $error("short jump target wrong");
endmodule
`default_nettype wire

// >>> cpu_stack_rotate_bit_exec_tb.sv
// Self-checking testbench for the stack, rotate, bit and jump executor
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_rotate_bit_exec_tb;
    logic                 clk_sys;
    logic                 reset_n;
    csr_pkg::csr_instr_t  instr_d;
    csr_pkg::csr_irq_t    irq_d;
    logic                 instr_ready;
    logic [15:0]          pc;
    logic [7:0]           acc;
    logic [7:0]           stack_ptr;
    logic [7:0]           status_word;
    logic [1:0]           active_levels;
    localparam logic [15:0] VEC_HI = 16'h0A40;
    localparam logic [15:0] VEC_LO = 16'h05C0;
    int err_count = 0;
    int samples_checked = 0;
    int m_pc, m_acc, m_sp, m_psw, m_lv;
    int mem [256];
    logic [31:0] xs_r = 32'hAEA975CA;
    int r, i;
    int rot_ops [4];

    csr_exec dut_u (
        .clk_sys         (clk_sys),
        .reset_n         (reset_n),
        .instr           (instr_d),
        .instr_ready     (instr_ready),
        .irq             (irq_d),
        .irq_vector_high (VEC_HI),
        .irq_vector_low  (VEC_LO),
        .pc              (pc),
        .acc             (acc),
        .stack_ptr       (stack_ptr),
        .status_word     (status_word),
        .active_levels   (active_levels)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    //////////////////////////////////////////////////////////////////////////
    function automatic int xs();
        xs_r = xs_r ^ (xs_r << 13);
        xs_r = xs_r ^ (xs_r >> 17);
        xs_r = xs_r ^ (xs_r << 5);
        return int'(xs_r);
    endfunction

    function automatic int rd(int a);
        if (a == 'hE0) return m_acc;
        if (a == 'hD0) return m_psw;
        if (a == 'h81) return m_sp;
        return mem[a];
    endfunction

    task automatic wr(int a, int v);
        if (a == 'hE0) m_acc = v & 255;
        else if (a == 'hD0) m_psw = v & 255;
        else if (a == 'h81) m_sp = v & 255;
        else mem[a] = v & 255;
    endtask

    // Behavioural model of one instruction
    task automatic m_step(int op, int opd);
        int t;
        int ba;
        m_pc = m_pc + 1;
        case (op)
            'h42: begin mem[opd] = mem[opd] | m_acc; m_pc++; end
            'hD0: begin wr(opd, mem[m_sp]); m_sp = (m_sp - 1) & 255; m_pc++; end
            'hC0: begin m_sp = (m_sp + 1) & 255; mem[m_sp] = rd(opd); m_pc++; end
            'h22, 'h32: begin
                m_pc = mem[m_sp] << 8;
                m_sp = (m_sp - 1) & 255;
                m_pc = m_pc | mem[m_sp];
                m_sp = (m_sp - 1) & 255;
                if (op == 'h32) m_lv = m_lv[1] ? (m_lv & 1) : 0;
            end
            'h23: m_acc = ((m_acc << 1) | (m_acc >> 7)) & 255;
            'h03: m_acc = ((m_acc >> 1) | (m_acc << 7)) & 255;
            'h33: begin
                t = m_acc >> 7;
                m_acc = ((m_acc << 1) | (m_psw >> 7)) & 255;
                m_psw = (m_psw & 'h7F) | (t << 7);
            end
            'h13: begin
                t = m_acc & 1;
                m_acc = (m_acc >> 1) | (m_psw & 'h80);
                m_psw = (m_psw & 'h7F) | (t << 7);
            end
            'hD3: m_psw = m_psw | 'h80;
            'hD2: begin
                ba = (opd < 'h80) ? ('h20 + opd / 8) : (opd & 'hF8);
                wr(ba, rd(ba) | (1 << (opd & 7)));
                m_pc++;
            end
            'h80: m_pc = m_pc + 1 + ((opd < 128) ? opd : opd - 256);
            default: ;
        endcase
        m_pc = m_pc & 'hFFFF;
        m_psw = (m_psw & 'hFE) | int'(^m_acc[7:0]);
    endtask

    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic check_all();
        check("pc", pc, m_pc[15:0]);
        check("acc", {8'h00, acc}, m_acc[15:0]);
        check("stack_ptr", {8'h00, stack_ptr}, m_sp[15:0]);
        check("status_word", {8'h00, status_word}, m_psw[15:0]);
        check("active_levels", {14'h0000, active_levels}, m_lv[15:0]);
    endtask
    //////////////////////////////////////////////////////////////////////////
    // Present one instruction, hold it until the executor is ready again
    task automatic exec(int op, int opd);
        int n;
        int two_cyc;
        two_cyc = (op == 'hD0 || op == 'hC0 || op == 'h80
                   || op == 'h22 || op == 'h32) ? 1 : 0;
        @(posedge clk_sys);
        instr_d.valid   <= 1'b1;
        instr_d.opcode  <= op[7:0];
        instr_d.operand <= opd[7:0];
        @(posedge clk_sys);
        #1;
        n = 0;
        while (instr_ready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        instr_d.valid <= 1'b0;
        m_step(op, opd);
        check_all();
        check("cycles", n[15:0], two_cyc[15:0]);
    endtask

    // Interrupt entry: pushes pc low then high, jumps to the vector
    task automatic irq_entry(int lvl);
        int n;
        n = 0;
        while ((active_levels !== lvl[1:0] || instr_ready !== 1'b1) && n < 30) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        m_sp = (m_sp + 1) & 255;
        mem[m_sp] = m_pc & 255;
        m_sp = (m_sp + 1) & 255;
        mem[m_sp] = m_pc >> 8;
        m_pc = lvl[1] ? VEC_HI : VEC_LO;
        m_lv = lvl;
        check_all();
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
        m_pc = 0; m_acc = 0; m_sp = 'h07; m_psw = 0; m_lv = 0;
        check_all();
        check("ready_in_reset", {15'h0000, instr_ready}, 16'h0000);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
        check("ready_after_reset", {15'h0000, instr_ready}, 16'h0001);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        complete_run();
    end

    initial begin
        reset_n = 1'b0;
        instr_d = '0;
        irq_d = '0;
        rot_ops = '{'h23, 'h33, 'h03, 'h13};
        for (i = 0; i < 256; i++) mem[i] = 0;
        do_reset();
        for (i = 0; i < 6; i++) exec(csr_pkg::OP_SET_BIT, 'hE0 | (xs() & 7));
        exec(csr_pkg::OP_SET_BIT, 'hD5);
        exec(csr_pkg::OP_SET_CARRY, 0);
        for (i = 0; i < 24; i++) begin
            r = xs();
            if (r[5]) exec(csr_pkg::OP_SET_BIT, 'hE0 | (r & 7));
            exec(rot_ops[(r >> 8) & 3], 0);
        end
        // Stack traffic and OR into memory
        exec(csr_pkg::OP_PUSH, 'hE0);
        exec(csr_pkg::OP_POP, 'h30);
        exec(csr_pkg::OP_ROT_L, 0);
        exec(csr_pkg::OP_OR_TO_MEM, 'h30);
        exec(csr_pkg::OP_PUSH, 'h30);
        exec(csr_pkg::OP_POP, 'hE0);
        exec(csr_pkg::OP_PUSH, 'hD0);
        exec(csr_pkg::OP_ROT_R, 0);
        exec(csr_pkg::OP_SET_BIT, 'hE0 | (xs() & 7));
        exec(csr_pkg::OP_POP, 'hD0);
        exec(csr_pkg::OP_PUSH, 'h81);
        exec(csr_pkg::OP_POP, 'hE0);
        // RAM bit area goes through byte 20h
        exec(csr_pkg::OP_PUSH, 'hE0);
        exec(csr_pkg::OP_POP, 'h20);
        exec(csr_pkg::OP_SET_BIT, xs() & 7);
        exec(csr_pkg::OP_PUSH, 'h20);
        exec(csr_pkg::OP_POP, 'hE0);
        exec(csr_pkg::OP_PUSH, 'hE0);
        exec(csr_pkg::OP_ROT_RC, 0);
        exec(csr_pkg::OP_PUSH, 'hE0);
        exec(csr_pkg::OP_SUB_EXIT, 0);
        exec('hA5, 0);
        // Jump offsets at both ends of the range
        exec(csr_pkg::OP_SHORT_JUMP, 'h7F);
        exec(csr_pkg::OP_SHORT_JUMP, 'h80);
        for (i = 0; i < 2; i++) exec(csr_pkg::OP_SHORT_JUMP, xs() & 255);
        // Nesting: low refused while in service, high pre-empts
        @(posedge clk_sys);
        irq_d.low <= 1'b1;
        irq_entry(1);
        exec(csr_pkg::OP_ROT_LC, 0);
        @(posedge clk_sys);
        irq_d.high <= 1'b1;
        irq_entry(3);
        irq_d.high <= 1'b0;
        exec(csr_pkg::OP_SET_CARRY, 0);
        exec(csr_pkg::OP_INT_EXIT, 0);
        exec(csr_pkg::OP_INT_EXIT, 0);
        irq_entry(1);
        irq_d.low <= 1'b0;
        exec(csr_pkg::OP_INT_EXIT, 0);
        do_reset();
        exec(csr_pkg::OP_SHORT_JUMP, 'hFE);
        complete_run();
    end
endmodule
`default_nettype wire
